//--- verilog/ssr_pkg.sv
// Constants and types shared by the synchronous serial receiver
// Assumes an 8-bit register port and a single system clock
package ssr_pkg;
  // Bus widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CHAR_W = 9;
  localparam int DIV_W  = 16;
  localparam int CNT_W  = 18;

  // Register offsets
  localparam logic [2:0] ADDR_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_DATA   = 3'h2;
  localparam logic [2:0] ADDR_DIV_LO = 3'h3;
  localparam logic [2:0] ADDR_DIV_HI = 3'h4;

  // Control register bit positions
  localparam int CTRL_SERIAL_PORT_ENABLE  = 7;
  localparam int CTRL_CLOCK_SOURCE_MASTER = 6;
  localparam int CTRL_NINE_BIT            = 5;
  localparam int CTRL_SINGLE_RECEIVE      = 4;
  localparam int CTRL_CONTINUOUS_RECEIVE  = 3;
  localparam int CTRL_HIGH_SPEED          = 2;
  localparam int CTRL_WIDE_BAUD           = 1;
  localparam int CTRL_IRQ_ENABLE          = 0;

  // Status register bit positions
  localparam int STAT_IRQ_FLAG = 0;
  localparam int STAT_OVERRUN  = 1;
  localparam int STAT_NINTH    = 2;
  localparam int STAT_COUNT    = 3;

  // Character lengths and FIFO size
  localparam logic [3:0] NBITS_8    = 4'h8;
  localparam logic [3:0] NBITS_9    = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST  = 8'h00;

  typedef enum logic [2:0] {
    SSR_PH_IDLE = 3'b001,
    SSR_PH_LOW  = 3'b010,
    SSR_PH_HIGH = 3'b100
  } ssr_phase_t;

  typedef struct packed {
    logic [1:0]        clk_sync;
    logic [1:0]        dat_sync;
    logic              clk_prev;
    logic              serial_port_enable;
    logic              clock_source_master;
    logic              nine_bit_receive_enable;
    logic              single_receive_enable;
    logic              continuous_receive_enable;
    logic              high_speed_baud_select;
    logic              wide_baud_generator_select;
    logic              receive_irq_enable;
    logic [7:0]        baud_divisor_low;
    logic [7:0]        baud_divisor_high;
    ssr_phase_t        phase;
    logic [8:0]        receive_shift_reg;
    logic [3:0]        bitcnt;
    logic [1:0][8:0]   fifo;
    logic [1:0]        count;
    logic              overrun_error_flag;
    logic              ovr_cont;
    logic              clk_out;
    logic              clk_oe;
    logic              data_oe;
    logic              irq;
    logic [7:0]        rdata;
  } ssr_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } ssr_baud_state_t;
endpackage

//--- verilog/ssr_baud_if.sv
// Link between the receiver core and its bit clock generator
// Assumes both ends run on the same system clock
`timescale 1ns/10ps
interface ssr_baud_if;
  logic [15:0] divisor;
  logic        high_speed;
  logic        run;
  logic        tick;
  modport gen  (input divisor, input high_speed, input run, output tick);
  modport user (output divisor, output high_speed, output run, input tick);
endinterface

//--- verilog/ssr_baud.sv
// Half-bit tick generator for the master bit clock
// Assumes run drops whenever no character is being clocked
`timescale 1ns/10ps
module ssr_baud (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Core side
  ssr_baud_if.gen  bif
);
  import ssr_pkg::*;

  ssr_baud_state_t st;
  ssr_baud_state_t nx;
  logic [CNT_W-1:0] limit;

  // RULE22 - divisor sets period
  always_comb begin
    nx = st;
    nx.tick = 1'b0;
    // Low speed stretches each half bit by four
    limit = bif.high_speed ? {2'b00, bif.divisor} : {bif.divisor, 2'b11};
    if (!bif.run) begin
      nx.cnt = '0;
    end else if (st.cnt >= limit) begin
      nx.cnt = '0;
      nx.tick = 1'b1;
    end else begin
      nx.cnt = st.cnt + 18'h00001;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign bif.tick = st.tick;
endmodule

//--- verilog/ssr_receiver.sv
// Synchronous serial receiver: master or slave clocking, two-deep FIFO
// Assumes pins arrive asynchronous and a simple strobe register port
// Functional notes
// RULE1 - As master receiver the data pin driver stays off.
// RULE2 - Reception starts when single or continuous receive is set.
// RULE3 - Single receive clocks one character then clears itself.
// RULE4 - Continuous receive clocks until cleared; clearing aborts the character.
// RULE5 - Both set: single clears after first character, continuous carries on.
// RULE6 - Data is sampled on the clock trailing edge into the shift register.
// RULE7 - A finished character sets the flag and enters the FIFO.
// RULE8 - Data register shows the low eight bits of the oldest character.
// RULE9 - Flag stays set while the FIFO holds unread characters.
// RULE10 - As slave the clock comes from the pin and its driver is off.
// RULE11 - Data changes on the leading edge, valid at trailing edge.
// RULE12 - External master gives only one clock per data bit.
// RULE13 - A third character with a full FIFO sets overrun.
// RULE14 - Overrun keeps FIFO contents and blocks further characters.
// RULE15 - Overrun from single mode clears on a data read.
// RULE16 - Overrun from continuous mode clears by clearing continuous or port enable.
// RULE17 - Nine-bit mode shifts nine bits; ninth bit shows the oldest character's.
// RULE18 - Software reads the ninth bit before the low byte.
// RULE19 - Software sets up divisor and mode before enabling reception.
// RULE20 - Interrupt request rises on data only with the interrupt enable set.
// RULE21 - Reading the data register pops the oldest character.
// RULE22 - Master bit period follows the divisor and speed bits.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module ssr_receiver (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Register port
  input  wire logic [ssr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ssr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output wire logic [ssr_pkg::DATA_W-1:0] reg_rdata,
  // Serial clock pin
  input  wire logic                       serial_clock_pin_in,
  output wire logic                       serial_clock_pin_out,
  output wire logic                       serial_clock_pin_oe,
  // Serial data pin
  input  wire logic                       serial_data_pin_in,
  output wire logic                       serial_data_pin_out,
  output wire logic                       serial_data_pin_oe,
  // Interrupt request
  output wire logic                       receive_irq_req
);
  import ssr_pkg::*;

  ssr_state_t st;
  ssr_state_t nx;
  logic       pop;
  logic       push;
  logic       trail;
  logic       abort;
  logic       active;
  logic [8:0] sh;
  logic [8:0] chr;
  logic [1:0] c;
  logic [3:0] nbits;
  logic [7:0] head_low;

  ssr_baud_if bif ();

  // Bit clock generator runs only while a master character is open
  assign bif.divisor    = st.wide_baud_generator_select ?
                          {st.baud_divisor_high, st.baud_divisor_low} :
                          {8'h00, st.baud_divisor_low};
  assign bif.high_speed = st.high_speed_baud_select;
  assign bif.run        = st.serial_port_enable & st.clock_source_master &
                          (st.phase != SSR_PH_IDLE);

  ssr_baud u_baud (
    .clk     (clk),
    .sys_rst (sys_rst),
    .bif     (bif)
  );

  // RULE17 - character length select
  assign nbits    = st.nine_bit_receive_enable ? NBITS_9 : NBITS_8;
  assign head_low = st.fifo[0][7:0];

  // Next-state logic for the whole receiver
  always_comb begin
    nx     = st;
    pop    = 1'b0;
    push   = 1'b0;
    trail  = 1'b0;
    abort  = 1'b0;
    sh     = st.receive_shift_reg;
    chr    = 9'h000;
    c      = st.count;
    nx.rdata = 8'h00;
    // Pin synchronisers; stage one feeds stage two only
    nx.clk_sync = {st.clk_sync[0], serial_clock_pin_in};
    nx.dat_sync = {st.dat_sync[0], serial_data_pin_in};
    nx.clk_prev = st.clk_sync[1];

    // Register writes
    if (reg_wr) begin
      if (reg_addr == ADDR_CTRL) begin
        nx.serial_port_enable         = reg_wdata[CTRL_SERIAL_PORT_ENABLE];
        nx.clock_source_master        = reg_wdata[CTRL_CLOCK_SOURCE_MASTER];
        nx.nine_bit_receive_enable    = reg_wdata[CTRL_NINE_BIT];
        nx.single_receive_enable      = reg_wdata[CTRL_SINGLE_RECEIVE];
        nx.continuous_receive_enable  = reg_wdata[CTRL_CONTINUOUS_RECEIVE];
        nx.high_speed_baud_select     = reg_wdata[CTRL_HIGH_SPEED];
        nx.wide_baud_generator_select = reg_wdata[CTRL_WIDE_BAUD];
        nx.receive_irq_enable         = reg_wdata[CTRL_IRQ_ENABLE];
        // RULE4 - clearing aborts character
        abort = st.continuous_receive_enable & ~reg_wdata[CTRL_CONTINUOUS_RECEIVE];
      end else if (reg_addr == ADDR_DIV_LO) begin
        nx.baud_divisor_low = reg_wdata;
      end else if (reg_addr == ADDR_DIV_HI) begin
        nx.baud_divisor_high = reg_wdata;
      end
    end

    // Register reads; data stands one cycle after the strobe
    if (reg_rd) begin
      if (reg_addr == ADDR_CTRL) begin
        nx.rdata = {st.serial_port_enable, st.clock_source_master,
                    st.nine_bit_receive_enable, st.single_receive_enable,
                    st.continuous_receive_enable, st.high_speed_baud_select,
                    st.wide_baud_generator_select, st.receive_irq_enable};
      end else if (reg_addr == ADDR_STATUS) begin
        // RULE17 - ninth bit view
        nx.rdata = {3'b000, st.count, st.fifo[0][8], st.overrun_error_flag,
                    (st.count != 2'h0)};
      end else if (reg_addr == ADDR_DATA) begin
        // RULE8 - oldest low byte
        nx.rdata = head_low;
        // RULE21 - read pops FIFO
        pop = (st.count != 2'h0);
      end else if (reg_addr == ADDR_DIV_LO) begin
        nx.rdata = st.baud_divisor_low;
      end else if (reg_addr == ADDR_DIV_HI) begin
        nx.rdata = st.baud_divisor_high;
      end
    end

    // RULE2 - either enable starts
    active = st.serial_port_enable & ~st.overrun_error_flag &
             (st.single_receive_enable | st.continuous_receive_enable);

    // Bit engine; an abort drops the partial character
    if (!active || abort) begin
      nx.phase   = SSR_PH_IDLE;
      nx.bitcnt  = 4'h0;
      nx.clk_out = 1'b0;
    end else if (st.clock_source_master) begin
      case (st.phase)
        SSR_PH_IDLE: begin
          nx.phase = SSR_PH_LOW;
        end
        SSR_PH_LOW: begin
          // RULE11 - leading edge out
          if (bif.tick) begin
            nx.clk_out = 1'b1;
            nx.phase   = SSR_PH_HIGH;
          end
        end
        SSR_PH_HIGH: begin
          if (bif.tick) begin
            nx.clk_out = 1'b0;
            nx.phase   = SSR_PH_LOW;
            trail      = 1'b1;
          end
        end
        default: begin
          nx.phase = SSR_PH_IDLE;
        end
      endcase
    end else begin
      // RULE10 - clock from pin
      nx.phase   = SSR_PH_IDLE;
      nx.clk_out = 1'b0;
      trail      = ~st.clk_sync[1] & st.clk_prev;
    end

    // RULE6 - trailing edge sample
    if (trail) begin
      sh = {st.dat_sync[1], st.receive_shift_reg[8:1]};
      nx.receive_shift_reg = sh;
      if (st.bitcnt == nbits - 4'h1) begin
        push      = 1'b1;
        nx.bitcnt = 4'h0;
        // LSB first, so an 8-bit character sits one place high
        chr = st.nine_bit_receive_enable ? sh : {1'b0, sh[8:1]};
        // RULE3 - single clears itself
        // RULE5 - continuous takes over
        if (st.single_receive_enable) begin
          nx.single_receive_enable = 1'b0;
          if (!st.continuous_receive_enable) begin
            nx.phase = SSR_PH_IDLE;
          end
        end
      end else begin
        nx.bitcnt = st.bitcnt + 4'h1;
      end
    end

    // FIFO pop shifts the younger entry forward
    if (pop) begin
      nx.fifo[0] = st.fifo[1];
      c = c - 2'h1;
    end

    // RULE15 - read clears overrun
    // RULE16 - continuous clear clears
    if (st.overrun_error_flag &&
        ((!st.ovr_cont && pop) || (st.ovr_cont && !st.continuous_receive_enable))) begin
      nx.overrun_error_flag = 1'b0;
    end

    // RULE7 - push into FIFO
    // RULE13 - full means overrun
    // RULE14 - contents kept
    if (push) begin
      if (c == FIFO_DEPTH) begin
        nx.overrun_error_flag = 1'b1;
        nx.ovr_cont           = st.continuous_receive_enable;
      end else begin
        nx.fifo[c[0]] = chr;
        c = c + 2'h1;
      end
    end
    nx.count = c;

    // Clearing the port enable resets the receive path
    if (!st.serial_port_enable) begin
      nx.count              = 2'h0;
      nx.overrun_error_flag = 1'b0;
      nx.ovr_cont           = 1'b0;
      nx.receive_shift_reg  = 9'h000;
      nx.bitcnt             = 4'h0;
    end

    // RULE9 - flag while unread
    // RULE20 - gated request
    nx.irq = st.receive_irq_enable & (nx.count != 2'h0);
    nx.clk_oe = st.serial_port_enable & st.clock_source_master;
    // RULE1 - data driver off
    nx.data_oe = 1'b0;
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
      st.phase <= SSR_PH_IDLE;
      st.baud_divisor_low <= DIV_RST;
      st.baud_divisor_high <= DIV_RST;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata            = st.rdata;
  assign serial_clock_pin_out = st.clk_out;
  assign serial_clock_pin_oe  = st.clk_oe;
  // Driven level is irrelevant while the driver stays off
  assign serial_data_pin_out  = st.data_oe;
  assign serial_data_pin_oe   = st.data_oe;
  assign receive_irq_req      = st.irq;

  // Helper: leading edges seen in the current master character
  logic       clk_d;
  logic [3:0] rise_cnt;
  logic [3:0] rise_seen;
  assign rise_seen = rise_cnt + {3'b000, st.clk_out & ~clk_d};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_d    <= 1'b0;
      rise_cnt <= 4'h0;
    end else begin
      clk_d <= st.clk_out;
      if (push || st.phase == SSR_PH_IDLE) begin
        rise_cnt <= 4'h0;
      end else if (st.clk_out && !clk_d) begin
        rise_cnt <= rise_cnt + 4'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_full_push;
    (st.count == FIFO_DEPTH) && push && !pop;
  endsequence

  sequence s_overrun_held;
    st.overrun_error_flag && st.serial_port_enable && !pop;
  endsequence

  a_data_drv_off: assert property ( // RULE1
    !serial_data_pin_oe) else $error("data pin driven");
  a_slave_clk_off: assert property ( // RULE10
    !st.clock_source_master |=> !serial_clock_pin_oe) else $error("slave drives clock");
  a_clock_count: assert property ( // RULE3
    st.clock_source_master && push |-> rise_seen == nbits)
    else $error("wrong clock count per character");
  a_single_clear: assert property ( // RULE5
    push && st.single_receive_enable && !(reg_wr && reg_addr == ADDR_CTRL)
    |=> !st.single_receive_enable) else $error("single enable not cleared");
  a_cont_abort: assert property ( // RULE4
    abort && st.clock_source_master |=> st.phase == SSR_PH_IDLE && !st.clk_out
    && st.bitcnt == 4'h0) else $error("abort did not stop clock");
  a_push_fifo: assert property ( // RULE7
    st.serial_port_enable && push && !pop && st.count == 2'h0
    |=> st.count == 2'h1 && st.fifo[0] == $past(chr)) else $error("push lost");
  a_read_data: assert property ( // RULE8
    reg_rd && reg_addr == ADDR_DATA |=> reg_rdata == $past(head_low))
    else $error("read data wrong");
  a_irq_level: assert property ( // RULE20
    st.receive_irq_enable && st.count == 2'h2 && !pop && st.serial_port_enable
    |=> receive_irq_req) else $error("request missing");
  a_overrun_set: assert property ( // RULE13
    s_full_push |=> st.overrun_error_flag) else $error("overrun not set");
  a_overrun_keep: assert property ( // RULE14
    s_overrun_held |=> $stable(st.fifo) && $stable(st.count))
    else $error("FIFO changed in overrun");
  a_ovr_read_clr: assert property ( // RULE15
    st.overrun_error_flag && !st.ovr_cont && pop |=> !st.overrun_error_flag)
    else $error("read did not clear overrun");
  a_ovr_cont_clr: assert property ( // RULE16
    st.overrun_error_flag && st.ovr_cont && !st.continuous_receive_enable
    |=> !st.overrun_error_flag) else $error("overrun not cleared");
endmodule

//--- testbench/ssr_partner.sv
// Far-side model: a synchronous serial device that feeds characters
// Assumes the bench resolves the shared clock wire and hands it back in
`timescale 1ns/10ps
module ssr_partner (
  // Resolved link clock and character length
  input  wire logic       serial_clk,
  input  wire logic [3:0] char_bits,
  // Lines this device drives
  output logic            data_line,
  output logic            clk_drive
);
  logic [8:0] char_q [$];
  logic [8:0] cur;
  int         idx;

  initial begin
    data_line = 1'b0;
    clk_drive = 1'b0;
    cur = 9'h000;
    idx = 0;
  end

  // change on leading edge
  // A new character is taken only at its first bit, LSB first
  always @(posedge serial_clk) begin
    if (idx == 0)
      cur = (char_q.size() > 0) ? char_q.pop_front() : 9'h1A5;
    data_line = cur[idx];
    idx = (idx + 1 == int'(char_bits)) ? 0 : idx + 1;
  end

  // Hold time over: flip the line so a stale bit is never mistaken for data
  always @(negedge serial_clk) begin
    if (idx == 0) begin
      #130 data_line = ~data_line;
    end
  end

  task load(input logic [8:0] c);
    char_q.push_back(c);
  endtask

  // Forget any partial character after an abort
  task flush;
    char_q.delete();
    idx = 0;
  endtask

  // one clock per bit
  // Clock idles low between frames, period 320 ns
  // Edges sit 10 ns off the system clock edges to keep sampling clean
  task clock_char(input logic [3:0] n);
    repeat (int'(n)) begin
      #90 clk_drive = 1'b1;
      #160 clk_drive = 1'b0;
      #70;
    end
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the synchronous serial receiver
// Assumes the partner model sits on the clock and data wires
`timescale 1ns/10ps
module tb;
  import ssr_pkg::*;
  typedef struct {
    logic [7:0] ctrl;
    logic [8:0] ch;
    logic [3:0] nb;
    logic [7:0] dat;
    logic       nth;
    logic       irq;
    logic       mst;
    logic [31:0] per;
  } ssr_row_t;
  logic        clk, sys_rst, reg_wr, reg_rd;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rv;
  logic        sck_out, sck_oe, sdo_out, sdo_oe, irq_req, dat_line, ext_clk;
  logic [3:0]  nbits;
  int          fail_count, check_count, pulse_cnt, i;
  time         t0, t1;
  wire         sck = sck_oe ? sck_out : ext_clk;
  // Rows: ctrl, char, bits, low byte, ninth, irq, master, period ns
  ssr_row_t rows [5] = '{
    '{8'hD5, 9'h05A, 4'h8, 8'h5A, 1'b0, 1'b1, 1'b1, 32'd320},
    '{8'hF4, 9'h1C3, 4'h9, 8'hC3, 1'b1, 1'b0, 1'b1, 32'd320},
    '{8'hD0, 9'h081, 4'h8, 8'h81, 1'b0, 1'b0, 1'b1, 32'd1280},
    '{8'hD7, 9'h03C, 4'h8, 8'h3C, 1'b0, 1'b1, 1'b1, 32'd320},
    '{8'hB5, 9'h1E7, 4'h9, 8'hE7, 1'b1, 1'b1, 1'b0, 32'd320}};

  ssr_receiver dut_u (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .serial_clock_pin_in  (sck),
    .serial_clock_pin_out (sck_out),
    .serial_clock_pin_oe  (sck_oe),
    .serial_data_pin_in   (dat_line),
    .serial_data_pin_out  (sdo_out),
    .serial_data_pin_oe   (sdo_oe),
    .receive_irq_req      (irq_req)
  );

  ssr_partner partner_u (
    .serial_clk (sck),
    .char_bits  (nbits),
    .data_line  (dat_line),
    .clk_drive  (ext_clk)
  );

  // 25 MHz system clock
  always #20 clk = ~clk;

  // Count link clock rising edges and time the first period
  always @(posedge sck) begin
    if (pulse_cnt == 0) t0 = $time;
    if (pulse_cnt == 1) t1 = $time;
    pulse_cnt++;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge
  task rd(input logic [2:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task rdc(input logic [2:0] a, input logic [7:0] exp);
    rd(a);
    check({24'h0, rv}, {24'h0, exp});
  endtask

  // Poll status under a bound; running out ends the run
  task wait_st(input logic [7:0] mask, input logic [7:0] val);
    int n;
    for (n = 0; n < 600; n++) begin
      rd(ADDR_STATUS);
      if ((rv & mask) === val) break;
    end
    if (n == 600) begin
      fail_count++;
      $display("unexpected at %0t: status wait ran out", $time);
      stop_test();
    end
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    nbits = 4'h8;
    fail_count = 0;
    check_count = 0;
    pulse_cnt = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1 check({28'h0, sck_oe, sdo_oe, irq_req, 1'b0}, 32'h0);
    rdc(ADDR_CTRL, CTRL_RST);
    rdc(ADDR_DIV_LO, DIV_RST);
    rdc(ADDR_DIV_HI, DIV_RST);
    // Unmapped and read-only places ignore writes
    wr(3'h7, 8'hFF);
    rdc(3'h7, 8'h00);
    wr(ADDR_STATUS, 8'hFF);
    rdc(ADDR_STATUS, 8'h00);
    // Ordinary single-character receptions
    foreach (rows[r]) begin
      nbits <= rows[r].nb;
      partner_u.load(rows[r].ch);
      wr(ADDR_DIV_LO, 8'h03);
      // Narrow rows load a high byte that must be ignored
      wr(ADDR_DIV_HI, {7'h00, ~rows[r].ctrl[CTRL_WIDE_BAUD]});
      wr(ADDR_CTRL, rows[r].ctrl & 8'hE7);
      pulse_cnt = 0;
      wr(ADDR_CTRL, rows[r].ctrl);
      if (!rows[r].mst) partner_u.clock_char(rows[r].nb);
      wait_st(8'h18, 8'h08);
      check(pulse_cnt, {28'h0, rows[r].nb});
      check(t1 - t0, rows[r].per);
      check({30'h0, sdo_oe, sdo_out}, 32'h0);
      check({31'h0, sck_oe}, {31'h0, rows[r].mst});
      check({31'h0, irq_req}, {31'h0, rows[r].irq});
      rdc(ADDR_CTRL, rows[r].ctrl & 8'hEF);
      rdc(ADDR_STATUS, {5'h01, rows[r].nth, 2'h1});
      rdc(ADDR_DATA, rows[r].dat);
      rdc(ADDR_STATUS, 8'h00);
      check({31'h0, irq_req}, 32'h0);
    end
    // Overrun while single receive only
    nbits <= 4'h8;
    partner_u.load(9'h011);
    partner_u.load(9'h022);
    partner_u.load(9'h033);
    for (i = 1; i <= 3; i++) begin
      wr(ADDR_CTRL, 8'hD5);
      if (i < 3) wait_st(8'h18, (i == 1) ? 8'h08 : 8'h10);
      else wait_st(8'h02, 8'h02);
    end
    rdc(ADDR_STATUS, 8'h13);
    check({31'h0, irq_req}, 32'h1);
    rdc(ADDR_DATA, 8'h11);
    rdc(ADDR_STATUS, 8'h09);
    rdc(ADDR_DATA, 8'h22);
    // Both enables: continuous carries on until the FIFO overflows
    wr(ADDR_CTRL, 8'h00);
    partner_u.flush();
    partner_u.load(9'h044);
    partner_u.load(9'h055);
    partner_u.load(9'h066);
    pulse_cnt = 0;
    wr(ADDR_CTRL, 8'hDC);
    wait_st(8'h02, 8'h02);
    rdc(ADDR_CTRL, 8'hCC);
    repeat (60) @(posedge clk);
    check(pulse_cnt, 32'd24);
    rdc(ADDR_DATA, 8'h44);
    rdc(ADDR_STATUS, 8'h0B);
    wr(ADDR_CTRL, 8'hC4);
    rdc(ADDR_STATUS, 8'h09);
    wr(ADDR_CTRL, 8'h00);
    rdc(ADDR_STATUS, 8'h00);
    // Clearing continuous mid-character aborts it
    partner_u.flush();
    pulse_cnt = 0;
    wr(ADDR_CTRL, 8'hCC);
    for (i = 0; i < 300 && pulse_cnt < 3; i++) @(posedge clk);
    // Running out of clock edges ends the run
    if (i == 300) begin
      fail_count++;
      $display("unexpected at %0t: clock wait ran out", $time);
      stop_test();
    end
    wr(ADDR_CTRL, 8'hC4);
    repeat (2) @(posedge clk);
    #1 i = pulse_cnt;
    repeat (60) @(posedge clk);
    check(pulse_cnt, i);
    check({31'h0, sck_out}, 32'h0);
    rdc(ADDR_STATUS, 8'h00);
    partner_u.flush();
    partner_u.load(9'h096);
    wr(ADDR_CTRL, 8'hD4);
    wait_st(8'h18, 8'h08);
    rdc(ADDR_DATA, 8'h96);
    stop_test();
  end
endmodule
